// ==== pbs_pkg.sv ====
// Purpose: shared constants for the pipelined burst sram front end
// Assumes: one clock, MCLK at 250 MHz
// Notes:   timing counts derived from the clock period
package pbs_pkg;
	localparam int unsigned CLK_PERIOD_PS     = 4000;
	localparam int unsigned SLEEP_ENTRY_CYC   = 2;
	localparam int unsigned SLEEP_RECOVERY_CYC = 2;
	localparam int unsigned ADDR_W_DEF        = 10;
	localparam int unsigned LANES_DEF         = 4;
	localparam logic [1:0]  BURST_START       = 2'h0;

	typedef enum logic [1:0] {
		PBS_IDLE  = 2'b00,
		PBS_READ  = 2'b01,
		PBS_WRITE = 2'b10,
		PBS_PWRT  = 2'b11
	} pbs_op_e;

	// next burst address in the selected order
	function automatic logic [1:0] pbs_next(input logic [1:0] start, input logic [1:0] cnt,
		input logic interleave);
		logic [1:0] c;
		c = cnt + 2'h1;
		pbs_next = interleave ? (start ^ c) : (start + c);
	endfunction : pbs_next
endpackage : pbs_pkg

// ==== pbs_sram.sv ====
// Purpose: synchronous front end and array of a pipelined burst sram
// Assumes: all pins except sleep, output enable and order select are synchronous to MCLK
// Notes:   data bus is split into input, output and output enable
//
`timescale 1ns/1ps

// Functional notes
// [RULE1] controller strobe write starts when selected, writing
// [RULE2] controller write one cycle, advance ignored
// [RULE3] global write stores all lanes
// [RULE4] byte write updates selected lanes only
// [RULE5] master raises output enable before driving data
// [RULE6] outputs float during any write cycle
// [RULE7] two-bit wraparound counter from low address bits
// [RULE8] advance low steps counter, reads and writes
// [RULE9] order strap high interleaved, low linear
// [RULE10] interleaved: start xor running count
// [RULE11] linear: start plus count modulo four
// [RULE12] sleep asynchronous, floats outputs, ignores inputs
// [RULE13] sleep entry and exit take two cycles
// [RULE14] array kept intact during sleep
// [RULE15] master deselects before sleep, recovers two cycles
// [RULE16] deselect conditions float outputs
// [RULE17] processor strobe access always begins read
// [RULE18] controller strobe begins burst, read or write
// [RULE19] controller high advance low continues burst
// [RULE20] no strobe advance high suspends burst
// [RULE21] internal write from global or byte enables
// [RULE22] output enable asynchronous, masked during writes
// [RULE23] read data registered, first cycle after deselect floats
// [RULE24] processor strobe write takes two clocks
module pbs_sram #(
	parameter int unsigned ADDR_W = pbs_pkg::ADDR_W_DEF,
	parameter int unsigned LANES  = pbs_pkg::LANES_DEF
) (
	input  wire logic                  MCLK,
	input  wire logic                  SRST,
	input  wire logic [ADDR_W-1:0]     ADDR,
	input  wire logic                  CHIP_ENABLE_FIRST_N,
	input  wire logic                  CHIP_ENABLE_SECOND,
	input  wire logic                  CHIP_ENABLE_THIRD_N,
	input  wire logic                  PROCESSOR_ADDR_STROBE_N,
	input  wire logic                  CONTROLLER_ADDR_STROBE_N,
	input  wire logic                  BURST_ADVANCE_N,
	input  wire logic                  GLOBAL_WRITE_N,
	input  wire logic                  BYTE_WRITE_ENABLE_N,
	input  wire logic [LANES-1:0]      LANE_WRITE_SELECT_N,
	input  wire logic                  OUTPUT_ENABLE_N,
	input  wire logic                  SLEEP_REQUEST,
	input  wire logic                  ORDER_SELECT,
	input  wire logic [8*LANES-1:0]    DATA_IN,
	output logic      [8*LANES-1:0]    DATA_OUT,
	output logic      [8*LANES-1:0]    DATA_OE,
	output logic                       SLEEPING
);

	// ****************************************
	// input conditioning
	// ****************************************
	logic       sleep_meta_ff;
	logic       sleep_sync_ff;
	logic       oe_meta_ff;
	logic       oe_sync_ff;
	logic [1:0] sleep_cnt_ff;
	logic       sleeping_ff;
	logic       order_meta_ff;
	logic       order_ff;

	always_ff @(posedge MCLK) begin
		sleep_meta_ff <= SLEEP_REQUEST;
		sleep_sync_ff <= sleep_meta_ff;
		oe_meta_ff    <= OUTPUT_ENABLE_N;
		oe_sync_ff    <= oe_meta_ff;
		order_meta_ff <= ORDER_SELECT;
		order_ff      <= order_meta_ff; // [RULE9]
	end

	// sleep state follows the synchronised request
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			sleeping_ff  <= 1'b0;
			sleep_cnt_ff <= 2'h0;
		end else if (sleep_sync_ff != sleeping_ff) begin
			sleeping_ff  <= 1'b1 ^ sleeping_ff; // [RULE12] [RULE13]
			sleep_cnt_ff <= 2'h0;
		end else if (sleep_cnt_ff != 2'h3) begin
			sleep_cnt_ff <= sleep_cnt_ff + 2'h1;
		end
	end

	// ****************************************
	// command decode
	// ****************************************
	wire asleep    = sleeping_ff;
	wire selected  = !CHIP_ENABLE_FIRST_N && CHIP_ENABLE_SECOND && !CHIP_ENABLE_THIRD_N;
	wire any_strb  = !PROCESSOR_ADDR_STROBE_N || !CONTROLLER_ADDR_STROBE_N;
	wire desel     = (CHIP_ENABLE_FIRST_N && !CONTROLLER_ADDR_STROBE_N)
		|| (!CHIP_ENABLE_FIRST_N && !selected && any_strb); // [RULE16]
	wire p_start   = selected && !PROCESSOR_ADDR_STROBE_N; // [RULE17]
	wire c_start   = selected && PROCESSOR_ADDR_STROBE_N && !CONTROLLER_ADDR_STROBE_N; // [RULE18]
	wire cont_ok   = !CONTROLLER_ADDR_STROBE_N ? 1'b0
		: (PROCESSOR_ADDR_STROBE_N || CHIP_ENABLE_FIRST_N);
	wire write_req = !GLOBAL_WRITE_N
		|| (!BYTE_WRITE_ENABLE_N && (LANE_WRITE_SELECT_N != {LANES{1'b1}})); // [RULE21]
	wire [LANES-1:0] lane_mask = !GLOBAL_WRITE_N ? {LANES{1'b1}}
		: (BYTE_WRITE_ENABLE_N ? {LANES{1'b0}} : ~LANE_WRITE_SELECT_N); // [RULE3] [RULE4]

	// ****************************************
	// burst address and operation state
	// ****************************************
	logic [ADDR_W-1:0] addr_ff;
	logic [1:0]        start_ff;
	logic [1:0]        cnt_ff;
	logic              active_ff;
	logic              was_desel_ff;
	pbs_pkg::pbs_op_e  op_ff;

	wire               cont    = !asleep && !desel && !p_start && !c_start && active_ff && cont_ok;
	wire               advance = cont && !BURST_ADVANCE_N; // [RULE8] [RULE19]
	wire               suspend = cont && BURST_ADVANCE_N;  // [RULE20]
	wire [1:0]         step    = pbs_pkg::pbs_next(start_ff, cnt_ff, order_ff); // [RULE10] [RULE11]
	wire [ADDR_W-1:0]  nxt_addr_val = advance ? {addr_ff[ADDR_W-1:2], step} : addr_ff;

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			addr_ff      <= '0;
			start_ff     <= pbs_pkg::BURST_START;
			cnt_ff       <= 2'h0;
			active_ff    <= 1'b0;
			was_desel_ff <= 1'b1;
			op_ff        <= pbs_pkg::PBS_IDLE;
		end else if (asleep) begin
			active_ff <= 1'b0; // [RULE12] [RULE14]
			op_ff     <= pbs_pkg::PBS_IDLE;
		end else if (p_start || c_start) begin
			addr_ff      <= ADDR; // [RULE2] [RULE7]
			start_ff     <= ADDR[1:0];
			cnt_ff       <= 2'h0;
			active_ff    <= 1'b1;
			was_desel_ff <= (op_ff == pbs_pkg::PBS_IDLE);
			op_ff        <= p_start ? pbs_pkg::PBS_READ
				: (write_req ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ); // [RULE1] [RULE17]
		end else if (desel) begin
			active_ff <= 1'b0;
			op_ff     <= pbs_pkg::PBS_IDLE;
		end else if (cont) begin
			addr_ff      <= nxt_addr_val;
			cnt_ff       <= advance ? cnt_ff + 2'h1 : cnt_ff;
			was_desel_ff <= 1'b0;
			op_ff        <= write_req ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ; // [RULE24]
		end else begin
			op_ff <= pbs_pkg::PBS_IDLE;
		end
	end

	// ****************************************
	// array write (self timed in the cycle after the command)
	// ****************************************
	logic [8*LANES-1:0] mem [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0]  wr_addr_ff;
	logic [8*LANES-1:0] wr_data_ff;
	logic [LANES-1:0]   wr_mask_ff;
	logic               wr_en_ff;

	// controller write captures at the strobe; continued write at its own edge
	wire wr_now = !asleep && ((c_start && write_req) || (cont && write_req)); // [RULE1] [RULE24]
	wire [ADDR_W-1:0] wr_addr = c_start ? ADDR : nxt_addr_val;

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			wr_en_ff <= 1'b0;
		end else begin
			wr_en_ff <= wr_now;
		end
		wr_addr_ff <= wr_addr;
		wr_data_ff <= DATA_IN;
		wr_mask_ff <= lane_mask;
	end

	always_ff @(posedge MCLK) begin
		for (int i = 0; i < LANES; i++) begin
			if (wr_en_ff && wr_mask_ff[i])
				mem[wr_addr_ff][8*i +: 8] <= wr_data_ff[8*i +: 8]; // [RULE3] [RULE4]
		end
	end

	// ****************************************
	// read pipeline and output drive
	// ****************************************
	logic [8*LANES-1:0] dout_ff;
	logic [8*LANES-1:0] doe_ff;
	logic               rd_valid_ff;

	wire rd_now   = !asleep && (op_ff == pbs_pkg::PBS_READ) && !was_desel_ff; // [RULE23]
	// a write seen at this edge releases the bus at once, whatever the pin says
	wire drive_en = rd_now && !oe_sync_ff && !wr_en_ff && !wr_now && !desel; // [RULE6] [RULE22]

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			doe_ff      <= '0;
			dout_ff     <= '0;
			rd_valid_ff <= 1'b0;
		end else begin
			dout_ff     <= mem[addr_ff]; // [RULE23]
			doe_ff      <= {(8*LANES){drive_en}};
			rd_valid_ff <= rd_now;
		end
	end

	assign DATA_OUT = dout_ff;
	assign DATA_OE  = doe_ff;
	assign SLEEPING = sleeping_ff;

	// ****************************************
	// checks
	// ****************************************
	property p_write_float;
		@(posedge MCLK) disable iff (SRST) wr_en_ff |=> (DATA_OE == '0);
	endproperty
	a_write_float: assert property (p_write_float) else $error("drive during write"); // [RULE6]

	property p_sleep_float;
		@(posedge MCLK) disable iff (SRST) sleeping_ff |=> (DATA_OE == '0);
	endproperty
	a_sleep_float: assert property (p_sleep_float) else $error("drive in sleep"); // [RULE12]

	property p_sleep_entry;
		@(posedge MCLK) disable iff (SRST)
			$rose(SLEEP_REQUEST) ##1 SLEEP_REQUEST[*2] |-> ##[0:2] sleeping_ff;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry late"); // [RULE13]

	property p_cwrite;
		@(posedge MCLK) disable iff (SRST) (!asleep && c_start && write_req) |=> wr_en_ff;
	endproperty
	a_cwrite: assert property (p_cwrite) else $error("controller write lost"); // [RULE1]

	property p_pread;
		@(posedge MCLK) disable iff (SRST) (!asleep && p_start) |=> op_ff == pbs_pkg::PBS_READ;
	endproperty
	a_pread: assert property (p_pread) else $error("processor start not read"); // [RULE17]

	property p_suspend;
		@(posedge MCLK) disable iff (SRST) suspend |=> $stable(addr_ff);
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspend moved address"); // [RULE20]

	property p_advance;
		@(posedge MCLK) disable iff (SRST)
			advance |=> addr_ff[1:0] == $past(step);
	endproperty
	a_advance: assert property (p_advance) else $error("bad burst step"); // [RULE8]

	property p_desel;
		@(posedge MCLK) disable iff (SRST) (!asleep && desel) |=> (DATA_OE == '0);
	endproperty
	a_desel: assert property (p_desel) else $error("drive after deselect"); // [RULE16]

	// ****************************************
	// output drive checks
	// ****************************************
	property p_write_now_float;
		@(posedge MCLK) disable iff (SRST)
			wr_now |=> (DATA_OE == '0);
	endproperty
	a_write_now_float: assert property (p_write_now_float) else $error("drive at write"); // [RULE6]

	property p_oe_mask;
		@(posedge MCLK) disable iff (SRST)
			oe_sync_ff |=> (DATA_OE == '0);
	endproperty
	a_oe_mask: assert property (p_oe_mask) else $error("drive with enable off"); // [RULE22]

	property p_drive_read;
		@(posedge MCLK) disable iff (SRST)
			(DATA_OE != '0) |-> rd_valid_ff;
	endproperty
	a_drive_read: assert property (p_drive_read) else $error("drive outside read"); // [RULE22]

	property p_first_float;
		@(posedge MCLK) disable iff (SRST)
			(!asleep && (p_start || c_start) && (op_ff == pbs_pkg::PBS_IDLE)) |=> ##1 (DATA_OE == '0);
	endproperty
	a_first_float: assert property (p_first_float) else $error("drive after idle"); // [RULE23]

	// ****************************************
	// sleep checks
	// ****************************************
	property p_sleep_exit;
		@(posedge MCLK) disable iff (SRST)
			$fell(SLEEP_REQUEST) ##1 !SLEEP_REQUEST[*2] |-> ##[0:2] !sleeping_ff;
	endproperty
	a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit late"); // [RULE13]

	property p_sleep_hold;
		@(posedge MCLK) disable iff (SRST)
			asleep |=> !wr_en_ff;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("write in sleep"); // [RULE14]

	property p_sleep_idle;
		@(posedge MCLK) disable iff (SRST)
			asleep |=> !active_ff;
	endproperty
	a_sleep_idle: assert property (p_sleep_idle) else $error("burst kept in sleep"); // [RULE12]

	// ****************************************
	// start, write and deselect checks
	// ****************************************
	property p_cstart_load;
		@(posedge MCLK) disable iff (SRST)
			(!asleep && c_start) |=> (addr_ff == $past(ADDR)) && (cnt_ff == 2'h0);
	endproperty
	a_cstart_load: assert property (p_cstart_load) else $error("controller start load"); // [RULE2]

	property p_pstart_load;
		@(posedge MCLK) disable iff (SRST)
			(!asleep && p_start) |=> (start_ff == $past(ADDR[1:0])) && (cnt_ff == 2'h0);
	endproperty
	a_pstart_load: assert property (p_pstart_load) else $error("counter load"); // [RULE7]

	property p_cstart_read;
		@(posedge MCLK) disable iff (SRST)
			(!asleep && c_start && !write_req) |=> (op_ff == pbs_pkg::PBS_READ);
	endproperty
	a_cstart_read: assert property (p_cstart_read) else $error("controller read lost"); // [RULE18]

	property p_cont_write;
		@(posedge MCLK) disable iff (SRST)
			(cont && write_req) |=> wr_en_ff;
	endproperty
	a_cont_write: assert property (p_cont_write) else $error("continued write lost"); // [RULE24]

	property p_lane_gw;
		@(posedge MCLK) disable iff (SRST)
			(wr_now && !GLOBAL_WRITE_N) |=> (wr_mask_ff == {LANES{1'b1}});
	endproperty
	a_lane_gw: assert property (p_lane_gw) else $error("global write lanes"); // [RULE3]

	property p_lane_bw;
		@(posedge MCLK) disable iff (SRST)
			(wr_now && GLOBAL_WRITE_N) |=> (wr_mask_ff == ~$past(LANE_WRITE_SELECT_N));
	endproperty
	a_lane_bw: assert property (p_lane_bw) else $error("byte write lanes"); // [RULE4]

	property p_desel_idle;
		@(posedge MCLK) disable iff (SRST)
			(!asleep && desel) |=> (op_ff == pbs_pkg::PBS_IDLE);
	endproperty
	a_desel_idle: assert property (p_desel_idle) else $error("deselect kept burst"); // [RULE16]

	// ****************************************
	// burst counter checks
	// ****************************************
	property p_order_ilv;
		@(posedge MCLK) disable iff (SRST)
			(advance && order_ff) |=> ((addr_ff[1:0] ^ start_ff) == cnt_ff);
	endproperty
	a_order_ilv: assert property (p_order_ilv) else $error("interleaved order"); // [RULE10]

	property p_order_lin;
		@(posedge MCLK) disable iff (SRST)
			(advance && !order_ff) |=> (addr_ff[1:0] == 2'(start_ff + cnt_ff));
	endproperty
	a_order_lin: assert property (p_order_lin) else $error("linear order"); // [RULE11]

	property p_advance_cnt;
		@(posedge MCLK) disable iff (SRST)
			advance |=> (cnt_ff == 2'($past(cnt_ff) + 2'h1));
	endproperty
	a_advance_cnt: assert property (p_advance_cnt) else $error("counter step"); // [RULE8]

	property p_suspend_cnt;
		@(posedge MCLK) disable iff (SRST)
			suspend |=> $stable(cnt_ff);
	endproperty
	a_suspend_cnt: assert property (p_suspend_cnt) else $error("suspend moved counter"); // [RULE20]

	c_cwrite:  cover property (@(posedge MCLK) c_start && write_req);
	c_advance: cover property (@(posedge MCLK) advance ##1 advance ##1 advance);
	c_read:    cover property (@(posedge MCLK) DATA_OE != '0);
	c_sleep:   cover property (@(posedge MCLK) $rose(sleeping_ff));
	c_wake:    cover property (@(posedge MCLK) !sleeping_ff && sleep_cnt_ff == 2'h2 && $past(sleeping_ff, 3));

endmodule : pbs_sram

// ==== pbs_host.sv ====
// Purpose: processor side model driving the sram strobes and data
// Assumes: one operation per call, pins change just after the clock rise
// Notes:   undriven data lines show the inverse of their last value
`timescale 1ns/1ps
module pbs_host (
	input  wire logic        mclk,
	output logic      [9:0]  addr,
	output logic      [8:0]  ctl,
	output logic      [3:0]  lane_sel_n,
	output logic      [31:0] data,
	output logic             sleep_request
);
	// ****
	// ctl: enables 8:6, proc 5, ctrl 4, adv 3, gw 2, bwe 1, oe 0
	// ****
	localparam logic [8:0] OPS [0:7] = '{9'h17E, 9'h16E, 9'h0AB, 9'h0AD,
		9'h0AE, 9'h176, 9'h098, 9'h17F};

	initial begin
		addr = 10'h000;
		ctl = 9'h17F;
		lane_sel_n = 4'hF;
		data = 32'h0000_0000;
		sleep_request = 1'b0;
	end

	task automatic op(input int k, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] bs);
		if (k inside {2, 3} && ctl[0] == 1'b0) begin
			ctl <= OPS[7];
			@(posedge mclk);
		end
		ctl <= OPS[k];
		addr <= a;
		lane_sel_n <= bs;
		data <= (k inside {2, 3}) ? d : ~data;
		@(posedge mclk);
	endtask : op

	task automatic sleep(input logic v);
		ctl <= OPS[7];
		@(posedge mclk);
		sleep_request <= v;
		repeat (4) @(posedge mclk);
	endtask : sleep
endmodule : pbs_host

// ==== pipelined_burst_sram_interface_tb.sv ====
// Purpose: self-checking bench for the pipelined burst sram front end
// Assumes: default widths, host model drives every control pin but reset and order select
// Notes:   reads checked after suspend cycles, so latency is free
`timescale 1ns/1ps
module pipelined_burst_sram_interface_tb;
	logic        mclk;
	logic        srst = 1'b1;
	logic        order_sel = 1'b1;
	logic [9:0]  addr;
	logic [8:0]  ctl;
	logic [3:0]  lsel_n;
	logic [31:0] din;
	logic [31:0] dout;
	logic [31:0] doe;
	logic        sleep_req;
	logic        sleeping;
	logic [15:0] lfsr = 16'h000B;
	logic [31:0] mem [0:1023];
	logic [31:0] w;
	logic [9:0]  base;
	logic [3:0]  bs;
	int          failures = 0;
	int          n_compared = 0;

	pbs_host u_host (.mclk(mclk), .addr(addr), .ctl(ctl), .lane_sel_n(lsel_n), .data(din),
		.sleep_request(sleep_req));
	pbs_sram #(.ADDR_W(10), .LANES(4)) uut (.MCLK(mclk), .SRST(srst), .ADDR(addr),
		.CHIP_ENABLE_FIRST_N(ctl[8]), .CHIP_ENABLE_SECOND(ctl[7]), .CHIP_ENABLE_THIRD_N(ctl[6]),
		.PROCESSOR_ADDR_STROBE_N(ctl[5]), .CONTROLLER_ADDR_STROBE_N(ctl[4]),
		.BURST_ADVANCE_N(ctl[3]), .GLOBAL_WRITE_N(ctl[2]), .BYTE_WRITE_ENABLE_N(ctl[1]),
		.LANE_WRITE_SELECT_N(lsel_n), .OUTPUT_ENABLE_N(ctl[0]), .SLEEP_REQUEST(sleep_req),
		.ORDER_SELECT(order_sel), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
		.SLEEPING(sleeping));

	// ****
	// helpers
	// ****
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction : rnd

	function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] m);
		for (int i = 0; i < 4; i++)
			if (!m[i]) o[8*i+:8] = n[8*i+:8];
		return o;
	endfunction : merge

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic settle(input logic [31:0] e);
		repeat (6) u_host.op(0, addr, 32'h0, 4'hF);
		#1;
		chk("read data", e, dout);
		chk("data drive", 32'hFFFF_FFFF, doe);
	endtask : settle

	task automatic report_and_stop();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	initial begin
		#40000;
		failures++;
		report_and_stop();
	end

	initial begin
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		for (int il = 1; il >= 0; il--) begin
			order_sel <= il[0];
			w = {16'h0000, rnd()};
			base = {w[9:2], 2'h0};
			for (int i = 0; i < 4; i++) begin
				w = {rnd(), rnd()};
				mem[base + 10'(i)] = w;
				u_host.op(2, base + 10'(i), w, 4'hF);
			end
			for (int s = 0; s < 4; s++)
				for (int k = 0; k < 4; k++) begin
					u_host.op(4, base + 10'(s), 32'h0, 4'hF);
					repeat (k) u_host.op(5, base, 32'h0, 4'hF);
					settle(mem[base + 10'(il ? s ^ k : (s + k) & 3)]);
				end
		end
		for (int i = 0; i < 8; i++) begin
			w = {16'h0000, rnd()};
			base = w[9:0];
			w = {rnd(), rnd()};
			mem[base] = w;
			u_host.op(2, base, w, 4'h0);
			w = {rnd(), rnd()};
			bs = (i == 0) ? 4'hF : w[3:0];
			mem[base] = merge(mem[base], w, bs);
			u_host.op(3, base, w, bs);
			u_host.op(6, base, 32'h0, 4'h0);
			settle(mem[base]);
		end
		repeat (4) u_host.op(1, base, 32'h0, 4'hF);
		#1;
		chk("deselect drive", 32'h0, doe);
		u_host.sleep(1'b1);
		#1;
		chk("sleep state", 32'h1, {31'h0, sleeping});
		chk("sleep drive", 32'h0, doe);
		u_host.op(2, base, ~mem[base], 4'h0);
		u_host.sleep(1'b0);
		#1;
		chk("wake state", 32'h0, {31'h0, sleeping});
		u_host.op(4, base, 32'h0, 4'hF);
		settle(mem[base]);
		repeat (6) u_host.op(7, base, 32'h0, 4'hF);
		#1;
		chk("masked drive", 32'h0, doe);
		report_and_stop();
	end
endmodule : pipelined_burst_sram_interface_tb
